//--- hdl/cml_pkg.sv
package cml_pkg;

   // Widths and sizes
   localparam int DATA_W = 8;
   localparam int MEM_DEPTH = 256;
   localparam int MEM_AW = 8;
   localparam int REG_AW = 4;

   // Register offsets on the plain register port
   localparam logic [REG_AW-1:0] REG_WORK_OFS = 4'h0;
   localparam logic [REG_AW-1:0] REG_STATUS_OFS = 4'h1;
   localparam logic [REG_AW-1:0] REG_CTRL_OFS = 4'h2;

   // Field positions
   localparam int STAT_CARRY_BIT = 0;
   localparam int STAT_NULL_BIT = 1;
   localparam int STAT_SLEEP_BIT = 2;
   localparam int STAT_EXPIRY_BIT = 3;
   localparam int CTRL_WDT_EN_BIT = 0;

   // Values after reset and fixed data values
   localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
   localparam logic [DATA_W-1:0] CTRL_RST = 8'h01;
   localparam logic [DATA_W-1:0] ZERO_VALUE = 8'h00;
   localparam logic [DATA_W-1:0] FILL_VALUE = 8'hff;

   // Watchdog timing
   localparam int CLK_HZ = 100_000_000;
   localparam int WDT_TIME_MS = 18;
   localparam int WDT_CYCLES_DEF = WDT_TIME_MS * (CLK_HZ / 1000);

   typedef enum logic [4:0] {
      OP_NOP = 5'h00,
      OP_SLEEP_ENTER = 5'h01,
      OP_WATCHDOG_KICK = 5'h02,
      OP_MOVE_STORE = 5'h03,
      OP_MOVE_LOAD = 5'h04,
      OP_VALUE_TEST = 5'h05,
      OP_LOAD_IMMEDIATE = 5'h06,
      OP_ZERO_WORK_REG = 5'h07,
      OP_ZERO_MEM = 5'h08,
      OP_FILL_MEM = 5'h09,
      OP_OR_TO_WORK = 5'h0a,
      OP_OR_TO_MEM = 5'h0b,
      OP_AND_TO_WORK = 5'h0c,
      OP_AND_TO_MEM = 5'h0d,
      OP_XOR_TO_WORK = 5'h0e,
      OP_XOR_TO_MEM = 5'h0f,
      OP_NIBBLE_SWAP_TO_WORK = 5'h10,
      OP_NIBBLE_SWAP_TO_MEM = 5'h11,
      OP_INVERT_TO_WORK = 5'h12,
      OP_INVERT_TO_MEM = 5'h13,
      OP_XOR_IMMEDIATE = 5'h14,
      OP_AND_IMMEDIATE = 5'h15,
      OP_OR_IMMEDIATE = 5'h16,
      OP_ROTATE_RIGHT_THRU_TO_WORK = 5'h17,
      OP_ROTATE_RIGHT_THRU_TO_MEM = 5'h18,
      OP_ROTATE_LEFT_THRU_TO_WORK = 5'h19,
      OP_ROTATE_LEFT_THRU_TO_MEM = 5'h1a,
      OP_SHIFT_LEFT_TO_WORK = 5'h1b,
      OP_SHIFT_LEFT_TO_MEM = 5'h1c,
      OP_SHIFT_RIGHT_TO_WORK = 5'h1d,
      OP_SHIFT_RIGHT_TO_MEM = 5'h1e
   } cml_op_e;

   typedef struct packed {
      cml_op_e op;
      logic [MEM_AW-1:0] addr;
      logic [DATA_W-1:0] imm;
   } cml_instr_s;

   typedef struct packed {
      logic watchdog_expiry_flag;
      logic sleep_entry_flag;
      logic result_null;
      logic carry;
   } cml_flags_s;

   typedef struct packed {
      logic [DATA_W-1:0] result;
      logic carry;
      logic to_work;
      logic to_mem;
      logic set_null;
      logic set_carry;
   } cml_alu_s;

   typedef enum logic [1:0] {
      ST_READY = 2'b00,
      ST_EXEC = 2'b01,
      ST_SLEEP = 2'b11
   } cml_state_e;

endpackage : cml_pkg

//--- hdl/cml_data_mem.sv
`timescale 1ns/1ns
module cml_data_mem
   import cml_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int AW = MEM_AW,
   parameter int DEPTH = MEM_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [AW-1:0] addr,
   input wire logic wr_en,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
);

   logic [DW-1:0] mem_q [DEPTH];
   logic [DW-1:0] rdata_q;

   // Array holds no reset; contents are undefined until written
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_q[addr] <= wdata;
      end
   end

   // Registered read of the presented address every cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= mem_q[addr];
      end
   end

   assign rdata = rdata_q;

endmodule : cml_data_mem

//--- hdl/cml_watchdog.sv
`timescale 1ns/1ns
module cml_watchdog
   import cml_pkg::*;
#(
   parameter int CYCLES = WDT_CYCLES_DEF,
   parameter int CW = $clog2(CYCLES + 1)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic kick,
   output logic expired
);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic exp_q;
   logic exp_d;

   // Count up while enabled; kick or disable restarts from zero
   always_comb begin
      cnt_d = cnt_q + CW'(1);
      exp_d = 1'b0;
      if (kick || !enable) begin
         cnt_d = '0;
      end else if (cnt_q == CW'(CYCLES - 1)) begin
         cnt_d = '0;
         exp_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end

   assign expired = exp_q;

endmodule : cml_watchdog

//--- hdl/cml_core.sv
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ns
module cml_core
   import cml_pkg::*;
#(
   parameter int WDT_CYCLES = WDT_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire cml_instr_s instr,
   output logic instr_ready,
   output logic op_done,
   output logic [DATA_W-1:0] work_register,
   output cml_flags_s flags,
   output logic sleeping,
   output logic wdt_timeout,
   input wire logic wake_pin,
   input wire logic [REG_AW-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata
);

   // Reset release synchroniser
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Wake pin synchroniser; only the second stage is read
   logic wake_meta_q;
   logic wake_sync_q;

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         wake_meta_q <= 1'b0;
         wake_sync_q <= 1'b0;
      end else begin
         wake_meta_q <= wake_pin;
         wake_sync_q <= wake_meta_q;
      end
   end

   // Operation decode and result; one table keeps every operation consistent
   function automatic cml_alu_s exec_op(
      input cml_op_e op,
      input logic [DATA_W-1:0] mem,
      input logic [DATA_W-1:0] work,
      input logic [DATA_W-1:0] imm,
      input logic carry_in
   );
      cml_alu_s a;
      a = '0;
      a.carry = carry_in;
      unique case (op)
         OP_MOVE_STORE: begin
            a.result = work;
            a.to_mem = 1'b1;
         end
         OP_MOVE_LOAD: begin
            a.result = mem;
            a.to_work = 1'b1;
            a.set_null = 1'b1;
         end
         OP_VALUE_TEST: begin
            a.result = mem;
            a.to_mem = 1'b1;
            a.set_null = 1'b1;
         end
         OP_LOAD_IMMEDIATE: begin
            a.result = imm;
            a.to_work = 1'b1;
         end
         OP_ZERO_WORK_REG, OP_ZERO_MEM: begin
            a.result = ZERO_VALUE;
            a.to_work = (op == OP_ZERO_WORK_REG);
            a.to_mem = (op == OP_ZERO_MEM);
            a.set_null = 1'b1;
         end
         OP_FILL_MEM: begin
            a.result = FILL_VALUE;
            a.to_mem = 1'b1;
         end
         OP_OR_TO_WORK, OP_OR_TO_MEM: begin
            a.result = mem | work;
            a.to_work = (op == OP_OR_TO_WORK);
            a.to_mem = (op == OP_OR_TO_MEM);
            a.set_null = 1'b1;
         end
         OP_AND_TO_WORK, OP_AND_TO_MEM: begin
            a.result = mem & work;
            a.to_work = (op == OP_AND_TO_WORK);
            a.to_mem = (op == OP_AND_TO_MEM);
            a.set_null = 1'b1;
         end
         OP_XOR_TO_WORK, OP_XOR_TO_MEM: begin
            a.result = mem ^ work;
            a.to_work = (op == OP_XOR_TO_WORK);
            a.to_mem = (op == OP_XOR_TO_MEM);
            a.set_null = 1'b1;
         end
         OP_NIBBLE_SWAP_TO_WORK, OP_NIBBLE_SWAP_TO_MEM: begin
            a.result = {mem[3:0], mem[7:4]};
            a.to_work = (op == OP_NIBBLE_SWAP_TO_WORK);
            a.to_mem = (op == OP_NIBBLE_SWAP_TO_MEM);
         end
         OP_INVERT_TO_WORK, OP_INVERT_TO_MEM: begin
            a.result = ~mem;
            a.to_work = (op == OP_INVERT_TO_WORK);
            a.to_mem = (op == OP_INVERT_TO_MEM);
            a.set_null = 1'b1;
         end
         OP_XOR_IMMEDIATE: begin
            a.result = work ^ imm;
            a.to_work = 1'b1;
            a.set_null = 1'b1;
         end
         OP_AND_IMMEDIATE: begin
            a.result = work & imm;
            a.to_work = 1'b1;
            a.set_null = 1'b1;
         end
         OP_OR_IMMEDIATE: begin
            a.result = work | imm;
            a.to_work = 1'b1;
            a.set_null = 1'b1;
         end
         OP_ROTATE_RIGHT_THRU_TO_WORK, OP_ROTATE_RIGHT_THRU_TO_MEM: begin
            a.result = {carry_in, mem[7:1]};
            a.carry = mem[0];
            a.set_carry = 1'b1;
            a.to_work = (op == OP_ROTATE_RIGHT_THRU_TO_WORK);
            a.to_mem = (op == OP_ROTATE_RIGHT_THRU_TO_MEM);
         end
         OP_ROTATE_LEFT_THRU_TO_WORK, OP_ROTATE_LEFT_THRU_TO_MEM: begin
            a.result = {mem[6:0], carry_in};
            a.carry = mem[7];
            a.set_carry = 1'b1;
            a.to_work = (op == OP_ROTATE_LEFT_THRU_TO_WORK);
            a.to_mem = (op == OP_ROTATE_LEFT_THRU_TO_MEM);
         end
         OP_SHIFT_LEFT_TO_WORK, OP_SHIFT_LEFT_TO_MEM: begin
            a.result = {mem[6:0], 1'b0};
            a.to_work = (op == OP_SHIFT_LEFT_TO_WORK);
            a.to_mem = (op == OP_SHIFT_LEFT_TO_MEM);
         end
         OP_SHIFT_RIGHT_TO_WORK, OP_SHIFT_RIGHT_TO_MEM: begin
            a.result = {1'b0, mem[7:1]};
            a.to_work = (op == OP_SHIFT_RIGHT_TO_WORK);
            a.to_mem = (op == OP_SHIFT_RIGHT_TO_MEM);
         end
         default: begin
            a.result = work; // Nop, sleep, kick and unused codes write nothing
         end
      endcase
      return a;
   endfunction : exec_op

   // Sequencer state
   cml_state_e state_q;
   cml_state_e state_d;
   cml_instr_s instr_q;
   cml_instr_s instr_d;
   logic ready_q;
   logic ready_d;
   logic done_q;
   logic done_d;
   logic sleep_q;
   logic sleep_d;

   // Datapath state
   logic [DATA_W-1:0] work_q;
   logic [DATA_W-1:0] work_d;
   cml_flags_s fl_q;
   cml_flags_s fl_d;
   logic [DATA_W-1:0] ctrl_q;
   logic [DATA_W-1:0] ctrl_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;

   // Memory and watchdog wiring
   logic [MEM_AW-1:0] mem_addr;
   logic [DATA_W-1:0] mem_rdata;
   logic mem_wr;
   logic wdt_kick;
   logic wdt_expired;
   logic exec_now;
   cml_alu_s alu;

   assign exec_now = (state_q == ST_EXEC);
   assign alu = exec_op(instr_q.op, mem_rdata, work_q, instr_q.imm, fl_q.carry);
   // Address comes straight from the request so the read lands in the execute cycle
   assign mem_addr = (state_q == ST_READY) ? instr.addr : instr_q.addr;
   assign mem_wr = exec_now && alu.to_mem;
   assign wdt_kick = exec_now && (instr_q.op == OP_WATCHDOG_KICK);

   // Two clocks per instruction cycle: read phase, then execute and write back
   always_comb begin
      state_d = state_q;
      instr_d = instr_q;
      unique case (state_q)
         ST_READY: begin
            if (instr_valid) begin
               instr_d = instr;
               state_d = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (instr_q.op == OP_SLEEP_ENTER) begin
               state_d = ST_SLEEP;
            end else begin
               state_d = ST_READY;
            end
         end
         ST_SLEEP: begin
            if (wake_sync_q || wdt_expired) begin
               state_d = ST_READY;
            end
         end
         default: begin
            state_d = ST_READY;
         end
      endcase
      ready_d = (state_d == ST_READY);
      sleep_d = (state_d == ST_SLEEP);
      done_d = exec_now;
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         state_q <= ST_READY;
         instr_q <= '0;
         ready_q <= 1'b0;
         done_q <= 1'b0;
         sleep_q <= 1'b0;
      end else begin
         state_q <= state_d;
         instr_q <= instr_d;
         ready_q <= ready_d;
         done_q <= done_d;
         sleep_q <= sleep_d;
      end
   end

   // Work register and flags; the core's own update beats a software write
   always_comb begin
      work_d = work_q;
      fl_d = fl_q;
      if (reg_wr && reg_addr == REG_WORK_OFS) begin
         work_d = reg_wdata;
      end
      if (reg_wr && reg_addr == REG_STATUS_OFS) begin
         fl_d.carry = reg_wdata[STAT_CARRY_BIT];
         fl_d.result_null = reg_wdata[STAT_NULL_BIT];
      end
      if (exec_now) begin
         if (alu.to_work) begin
            work_d = alu.result;
         end
         if (alu.set_null) begin
            fl_d.result_null = (alu.result == ZERO_VALUE);
         end
         if (alu.set_carry) begin
            fl_d.carry = alu.carry;
         end
         if (instr_q.op == OP_WATCHDOG_KICK) begin
            fl_d.sleep_entry_flag = 1'b0;
            fl_d.watchdog_expiry_flag = 1'b0;
         end
         if (instr_q.op == OP_SLEEP_ENTER) begin
            fl_d.sleep_entry_flag = 1'b1;
            fl_d.watchdog_expiry_flag = 1'b0;
         end
      end
      // Timeout last so a same-cycle kick cannot hide it
      if (wdt_expired) begin
         fl_d.watchdog_expiry_flag = 1'b1;
      end
   end

   // Control register and read port; unmapped offsets read as zero
   always_comb begin
      ctrl_d = ctrl_q;
      rdata_d = '0;
      if (reg_wr && reg_addr == REG_CTRL_OFS) begin
         ctrl_d = reg_wdata;
      end
      if (reg_rd) begin
         unique case (reg_addr)
            REG_WORK_OFS: begin
               rdata_d = work_q;
            end
            REG_STATUS_OFS: begin
               rdata_d[STAT_CARRY_BIT] = fl_q.carry;
               rdata_d[STAT_NULL_BIT] = fl_q.result_null;
               rdata_d[STAT_SLEEP_BIT] = fl_q.sleep_entry_flag;
               rdata_d[STAT_EXPIRY_BIT] = fl_q.watchdog_expiry_flag;
            end
            REG_CTRL_OFS: begin
               rdata_d = ctrl_q;
            end
            default: begin
               rdata_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         work_q <= WORK_RST;
         fl_q <= '0;
         ctrl_q <= CTRL_RST;
         rdata_q <= '0;
      end else begin
         work_q <= work_d;
         fl_q <= fl_d;
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
      end
   end

   // Single port suffices: reads and writes fall in different phases
   cml_data_mem #(
      .DW(DATA_W),
      .AW(MEM_AW),
      .DEPTH(MEM_DEPTH)
   ) u_mem (
      .clk(clk),
      .rst_n(rst_sync_q),
      .addr(mem_addr),
      .wr_en(mem_wr),
      .wdata(alu.result),
      .rdata(mem_rdata)
   );

   // Keeps running in sleep so a timeout can wake the core
   cml_watchdog #(
      .CYCLES(WDT_CYCLES)
   ) u_wdt (
      .clk(clk),
      .rst_n(rst_sync_q),
      .enable(ctrl_q[CTRL_WDT_EN_BIT]),
      .kick(wdt_kick),
      .expired(wdt_expired)
   );

   // Outputs taken straight from flops
   assign instr_ready = ready_q;
   assign op_done = done_q;
   assign work_register = work_q;
   assign flags = fl_q;
   assign sleeping = sleep_q;
   assign wdt_timeout = wdt_expired;
   assign reg_rdata = rdata_q;

endmodule : cml_core

//--- testbench/cml_core_monitor.sv
`timescale 1ns/1ns
module cml_core_monitor
   import cml_pkg::*;
#(
   parameter int WDT_CYCLES = WDT_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire cml_instr_s instr,
   input wire logic instr_ready,
   input wire logic op_done,
   input wire logic [DATA_W-1:0] work_register,
   input wire cml_flags_s flags,
   input wire logic sleeping,
   input wire logic wdt_timeout,
   input wire logic wake_pin,
   input wire logic [REG_AW-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata
);
   // Instruction accepted at this edge
   logic take;
   cml_op_e op;
   assign take = instr_valid && instr_ready;
   assign op = instr.op;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_ONE_CYCLE: assert property (
      take && op != OP_SLEEP_ENTER |=> !instr_ready ##1 (op_done && instr_ready))
      else $error("Instruction did not finish in one instruction cycle");
   // $past depth 2 reaches back to the taking edge
   AST_FLAGS_KEPT: assert property (
      take && op inside {OP_MOVE_STORE, OP_LOAD_IMMEDIATE, OP_FILL_MEM,
         OP_NIBBLE_SWAP_TO_WORK, OP_NIBBLE_SWAP_TO_MEM, OP_SHIFT_LEFT_TO_WORK,
         OP_SHIFT_LEFT_TO_MEM, OP_SHIFT_RIGHT_TO_WORK, OP_SHIFT_RIGHT_TO_MEM}
      |=> ##1 flags[1:0] == $past(flags[1:0], 2))
      else $error("Carry or null flag changed by a flag-neutral op");
   AST_LOAD_IMM: assert property (
      take && op == OP_LOAD_IMMEDIATE |=> ##1 work_register == $past(instr.imm, 2))
      else $error("Immediate not loaded into work register");
   AST_IMM_XOR: assert property (
      take && op == OP_XOR_IMMEDIATE
      |=> ##1 work_register == ($past(work_register, 2) ^ $past(instr.imm, 2)))
      else $error("Immediate xor result wrong");
   AST_ZERO_WORK: assert property (
      take && op == OP_ZERO_WORK_REG |=> ##1 work_register == ZERO_VALUE && flags.result_null)
      else $error("Work register not zeroed with null flag set");
   AST_NULL_TRACK: assert property (
      take && op inside {OP_MOVE_LOAD, OP_OR_TO_WORK, OP_AND_TO_WORK, OP_XOR_TO_WORK,
         OP_INVERT_TO_WORK, OP_XOR_IMMEDIATE, OP_AND_IMMEDIATE, OP_OR_IMMEDIATE}
      |=> ##1 flags.result_null == (work_register == ZERO_VALUE))
      else $error("Null flag does not follow work register result");
   AST_ROT_RIGHT: assert property (
      take && op == OP_ROTATE_RIGHT_THRU_TO_WORK |=> ##1 work_register[7] == $past(flags.carry, 2))
      else $error("Old carry not rotated into bit 7");
   AST_ROT_LEFT: assert property (
      take && op == OP_ROTATE_LEFT_THRU_TO_WORK |=> ##1 work_register[0] == $past(flags.carry, 2))
      else $error("Old carry not rotated into bit 0");
   AST_SLEEP: assert property (
      take && op == OP_SLEEP_ENTER |=> ##1 sleeping && flags.sleep_entry_flag && !instr_ready)
      else $error("Sleep entry not reflected");
   AST_KICK: assert property (
      take && op == OP_WATCHDOG_KICK |=> ##1 !flags.sleep_entry_flag)
      else $error("Watchdog kick left sleep flag set");
   AST_WDT_FLAG: assert property (
      wdt_timeout |-> ##[0:1] flags.watchdog_expiry_flag)
      else $error("Watchdog expiry flag not set on timeout");

   // Main scenarios reached
   COV_SLEEP: cover property (take && op == OP_SLEEP_ENTER);
   COV_WDT: cover property (wdt_timeout);
   COV_ROT: cover property (take && op == OP_ROTATE_LEFT_THRU_TO_MEM);
   COV_READ: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule : cml_core_monitor

bind cml_core cml_core_monitor #(.WDT_CYCLES(WDT_CYCLES)) u_mon (.clk(clk), .rst_n(rst_n),
   .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .op_done(op_done),
   .work_register(work_register), .flags(flags), .sleeping(sleeping),
   .wdt_timeout(wdt_timeout), .wake_pin(wake_pin), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

//--- testbench/cml_core_tb_top.sv
`timescale 1ns/1ns
module cml_core_tb_top
   import cml_pkg::*;
;
   `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
      $display("Error %0t: got %h expected %h", $time, g, e); end end
   // Short watchdog so expiry is reached quickly
   localparam int WDT_SIM = 50;
   logic clk, rst_n, instr_valid, wake_pin, reg_wr, reg_rd;
   logic instr_ready, op_done, sleeping, wdt_timeout;
   cml_instr_s instr;
   cml_flags_s flags;
   logic [REG_AW-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, work_register, d;
   logic [7:0] mv [3] = '{8'h96, 8'h01, 8'hff};
   logic [7:0] wv [3] = '{8'h3c, 8'h01, 8'hff};
   int n_mismatch, cmp_count, n;

   cml_core #(.WDT_CYCLES(WDT_SIM)) DUT (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
      .instr(instr), .instr_ready(instr_ready), .op_done(op_done),
      .work_register(work_register), .flags(flags), .sleeping(sleeping),
      .wdt_timeout(wdt_timeout), .wake_pin(wake_pin), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   task automatic conclude;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude

   task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   // Read data stands only in the cycle after the strobe
   task automatic reg_read(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : reg_read

   // One instruction; results are settled once op_done shows
   task automatic exec(input cml_op_e op, input logic [7:0] a, input logic [7:0] i);
      int k;
      k = 0;
      while (instr_ready !== 1'b1 && k < 100) begin
         @(posedge clk);
         #1 k++;
      end
      // A core that never comes ready counts against the run
      if (k == 100) n_mismatch++;
      @(posedge clk);
      instr <= '{op, a, i};
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      @(posedge clk);
      #1;
      if (op != OP_SLEEP_ENTER) `CHK(op_done, 1'b1)
   endtask : exec

   // Expected result, carry and destination of one datapath op
   task automatic model(input cml_op_e op, input logic [7:0] m, w, input logic c,
      output logic [7:0] r, output logic co, tw, un);
      co = c;
      case (op)
         OP_OR_TO_WORK, OP_OR_TO_MEM, OP_OR_IMMEDIATE: r = m | w;
         OP_AND_TO_WORK, OP_AND_TO_MEM, OP_AND_IMMEDIATE: r = m & w;
         OP_XOR_TO_WORK, OP_XOR_TO_MEM, OP_XOR_IMMEDIATE: r = m ^ w;
         OP_NIBBLE_SWAP_TO_WORK, OP_NIBBLE_SWAP_TO_MEM: r = {m[3:0], m[7:4]};
         OP_INVERT_TO_WORK, OP_INVERT_TO_MEM: r = ~m;
         OP_ROTATE_RIGHT_THRU_TO_WORK, OP_ROTATE_RIGHT_THRU_TO_MEM: {r, co} = {c, m};
         OP_ROTATE_LEFT_THRU_TO_WORK, OP_ROTATE_LEFT_THRU_TO_MEM: {co, r} = {m, c};
         OP_SHIFT_LEFT_TO_WORK, OP_SHIFT_LEFT_TO_MEM: r = m << 1;
         default: r = m >> 1;
      endcase
      tw = (op < OP_XOR_IMMEDIATE) ? !op[0] : (op < OP_ROTATE_RIGHT_THRU_TO_WORK || op[0]);
      un = op inside {[OP_OR_TO_WORK:OP_XOR_TO_MEM], OP_INVERT_TO_WORK, OP_INVERT_TO_MEM,
         [OP_XOR_IMMEDIATE:OP_OR_IMMEDIATE]};
   endtask : model

   // Operand in memory at 0x20, work register preset, null preset high
   task automatic alu(input cml_op_e op, input logic [7:0] m, w, input logic c);
      logic [7:0] r;
      logic co, tw, un;
      model(op, m, w, c, r, co, tw, un);
      exec(OP_LOAD_IMMEDIATE, 8'h00, m);
      exec(OP_MOVE_STORE, 8'h20, 8'h00);
      exec(OP_LOAD_IMMEDIATE, 8'h00, w);
      reg_write(REG_STATUS_OFS, {6'h00, 1'b1, c});
      exec(op, 8'h20, m);
      `CHK(flags.result_null, un ? (r == 8'h00) : 1'b1)
      `CHK(flags.carry, co)
      `CHK(work_register, tw ? r : w)
      exec(OP_MOVE_LOAD, 8'h20, 8'h00);
      `CHK(work_register, tw ? m : r)
   endtask : alu

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Cut a hung run short
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      conclude();
   end

   initial begin
      rst_n = 1'b0;
      instr_valid = 1'b0;
      instr = '0;
      wake_pin = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      reg_read(REG_CTRL_OFS, d);
      `CHK(d, CTRL_RST)
      reg_read(4'hf, d);
      `CHK(d, 8'h00)
      // Watchdog runs out, then a kick clears the expiry flag
      exec(OP_WATCHDOG_KICK, 8'h00, 8'h00);
      n = 0;
      while (wdt_timeout !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1 n++;
      end
      if (n == 400) n_mismatch++;
      @(posedge clk);
      #1 `CHK(flags.watchdog_expiry_flag, 1'b1)
      exec(OP_WATCHDOG_KICK, 8'h00, 8'h00);
      `CHK(flags.watchdog_expiry_flag, 1'b0)
      // Watchdog off so only the pin can wake the core
      reg_write(REG_CTRL_OFS, 8'h00);
      exec(OP_SLEEP_ENTER, 8'h00, 8'h00);
      `CHK({sleeping, flags.sleep_entry_flag, instr_ready}, 3'b110)
      // Register port stays live in sleep; only the sleep bit is up
      reg_read(REG_STATUS_OFS, d);
      `CHK(d, 8'h04)
      @(posedge clk) wake_pin <= 1'b1;
      n = 0;
      while (instr_ready !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1 n++;
      end
      if (n == 20) n_mismatch++;
      `CHK(sleeping, 1'b0)
      @(posedge clk) wake_pin <= 1'b0;
      exec(OP_WATCHDOG_KICK, 8'h00, 8'h00);
      `CHK(flags.sleep_entry_flag, 1'b0)
      exec(OP_LOAD_IMMEDIATE, 8'h00, 8'h3c);
      exec(OP_NOP, 8'h00, 8'h00);
      `CHK(work_register, 8'h3c)
      // Moves, test, zero and fill through memory 0x10 and 0x11
      exec(OP_MOVE_STORE, 8'h10, 8'h00);
      exec(OP_ZERO_WORK_REG, 8'h00, 8'h00);
      `CHK({work_register, flags.result_null}, {8'h00, 1'b1})
      exec(OP_VALUE_TEST, 8'h10, 8'h00);
      `CHK(flags.result_null, 1'b0)
      exec(OP_MOVE_LOAD, 8'h10, 8'h00);
      `CHK(work_register, 8'h3c)
      exec(OP_ZERO_MEM, 8'h10, 8'h00);
      `CHK(flags.result_null, 1'b1)
      // Load of the filled byte drops null first, so the zero test must raise it
      exec(OP_FILL_MEM, 8'h11, 8'h00);
      exec(OP_MOVE_LOAD, 8'h11, 8'h00);
      `CHK({work_register, flags.result_null}, {FILL_VALUE, 1'b0})
      exec(OP_VALUE_TEST, 8'h10, 8'h00);
      `CHK(flags.result_null, 1'b1)
      // Software write of the work register reads back
      reg_write(REG_WORK_OFS, 8'h5a);
      reg_read(REG_WORK_OFS, d);
      `CHK(d, 8'h5a)
      // Every op from OP_OR_TO_WORK to OP_SHIFT_RIGHT_TO_MEM with three operand sets
      for (int s = 0; s < 3; s++)
         for (int k = OP_OR_TO_WORK; k <= OP_SHIFT_RIGHT_TO_MEM; k++)
            alu(cml_op_e'(k), mv[s], wv[s], s[0]);
      conclude();
   end
endmodule : cml_core_tb_top
